// [mmpwm_map.svh]
`ifndef MMPWM_MAP_SVH
`define MMPWM_MAP_SVH
// ==========================================================
// register byte offsets
`define MMPWM_OFF_CTRL    12'h000
`define MMPWM_OFF_COUNT   12'h004
`define MMPWM_OFF_PRESC   12'h008
`define MMPWM_OFF_PCOUNT  12'h00c
`define MMPWM_OFF_MCTRL   12'h010
`define MMPWM_OFF_OUTCFG  12'h014
`define MMPWM_OFF_RELEASE 12'h018
`define MMPWM_OFF_STATUS  12'h01c
`define MMPWM_OFF_MASK    12'h020
`define MMPWM_OFF_MATCH0  12'h040
// ==========================================================
// ctrl fields
`define MMPWM_CTRL_RUN    0
`define MMPWM_CTRL_RST    1
`define MMPWM_CTRL_PWM    2
`define MMPWM_CTRL_CNT    3
`define MMPWM_CTRL_CSEL   4
`define MMPWM_CTRL_EDGE   5
// ==========================================================
// reset values
`define MMPWM_CTRL_RESET  32'h0000_0000
`define MMPWM_MATCH_RESET 32'h0000_0000
`endif

// [mmpwm_pkg.sv]
package mmpwm_pkg;
  // counter source selection
  typedef enum logic [1:0] {
    MMPWM_TIMER   = 2'b00,
    MMPWM_CAP_RISE = 2'b01,
    MMPWM_CAP_FALL = 2'b10,
    MMPWM_CAP_BOTH = 2'b11
  } mmpwm_src_t;
endpackage : mmpwm_pkg

// [mmpwm_tick_if.sv]
// ==========================================================
// count-tick carrier between the tick generator and the core
interface mmpwm_tick_if;
  logic        tick;
  logic [31:0] presc;
  logic [31:0] pcount;
  logic        clr;
  modport gen  (output tick, output pcount, input presc, input clr);
  modport core (input tick, input pcount, output presc, output clr);
endinterface : mmpwm_tick_if

// [mmpwm_tick.sv]
`include "mmpwm_map.svh"
// ==========================================================
// prescaler and tick source: peripheral clock or capture events
module mmpwm_tick (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        cnt_mode,
  input  wire logic [1:0]  src,
  input  wire logic [1:0]  cap_in,
  input  wire logic        cap_sel,
  mmpwm_tick_if.gen        t
);
  logic cap_q;
  logic cap_ev;
  // previous capture level for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap_q <= 1'b0;
    else
      cap_q <= cap_in[cap_sel];
  end
  // counter mode event selection
  always_comb
  begin
    case (src)
      2'b01:   cap_ev = cap_in[cap_sel] & ~cap_q;
      2'b10:   cap_ev = ~cap_in[cap_sel] & cap_q;
      2'b11:   cap_ev = cap_in[cap_sel] ^ cap_q;
      default: cap_ev = 1'b0;
    endcase
  end
  // prescaler: tick when count reaches the prescale value
  logic pre_hit;
  assign pre_hit = (t.pcount == t.presc);
  assign t.tick  = run & ~t.clr & (cnt_mode ? cap_ev : pre_hit);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      t.pcount <= 32'h0000_0000;
    else if (t.clr || cnt_mode || (run && pre_hit))
      t.pcount <= 32'h0000_0000;
    else if (run)
      t.pcount <= t.pcount + 32'h0000_0001;
  end
endmodule : mmpwm_tick

// [mmpwm_unit.sv]
// The APB register port and the placing of the registers were chosen for this implementation.
`include "mmpwm_map.svh"
module mmpwm_unit #(
  parameter int NMATCH = 7
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  cap_in,
  output logic      [6:1]  pwm_out,
  output logic             irq
);
  // ==========================================================
  // registers
  logic [31:0] ctrl;
  logic [31:0] tc;
  logic [20:0] mctrl;          // 3 bits per match: irq, reset, stop
  logic [13:0] outcfg;         // [6:1] enable, [13:9] double-edge select 2..6
  logic [6:0]  rel;            // released shadow pending
  logic [6:0]  status;
  logic [6:0]  mask;
  logic [31:0] presc_r;
  logic [31:0] shadow [NMATCH];
  logic [31:0] active [NMATCH];
  logic [6:0]  hit;
  logic [6:0]  fall_hit;       // count is one tick short of the match
  logic        period_hit;
  logic        wr;
  logic        rd;
  mmpwm_pkg::mmpwm_src_t src;
  mmpwm_tick_if tif ();

  assign wr  = psel & penable & pwrite;
  assign rd  = psel & ~pwrite;
  assign pready  = 1'b1;
  assign src = mmpwm_pkg::mmpwm_src_t'(ctrl[`MMPWM_CTRL_EDGE+1:`MMPWM_CTRL_EDGE]);
  assign tif.presc = ctrl[`MMPWM_CTRL_RST] ? 32'h0000_0000 : presc_r;
  assign tif.clr   = ctrl[`MMPWM_CTRL_RST];

  // ==========================================================
  // tick generator
  mmpwm_tick u_tick (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (ctrl[`MMPWM_CTRL_RUN]),
    .cnt_mode (ctrl[`MMPWM_CTRL_CNT]),
    .src      (src),
    .cap_in   (cap_in),
    .cap_sel  (ctrl[`MMPWM_CTRL_CSEL]),
    .t        (tif.gen)
  );

  // address to match index, returns 7 when not a match register
  function automatic logic [2:0] match_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - `MMPWM_OFF_MATCH0;
    if (a >= `MMPWM_OFF_MATCH0 && d[11:2] < 10'd7 && d[1:0] == 2'b00)
      match_idx = d[4:2];
    else
      match_idx = 3'd7;
  endfunction : match_idx

  // pick one action bit of every match: 0 stop, 1 reset, 2 irq
  function automatic logic [6:0] match_bits(input logic [20:0] mc, input int k);
    logic [6:0] b;
    for (int i = 0; i < 7; i++)
      b[i] = mc[3*i+k];
    return b;
  endfunction : match_bits

  // ==========================================================
  // match compare against active registers
  always_comb
  begin
    for (int i = 0; i < NMATCH; i++)
    begin
      hit[i]      = tif.tick & (tc == active[i]);
      fall_hit[i] = tif.tick & (tc + 32'h0000_0001 == active[i]);
    end
  end
  assign period_hit = hit[0];

  // ==========================================================
  // control register writes; stop-on-match clears run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= `MMPWM_CTRL_RESET;
      presc_r <= 32'h0000_0000;
      mctrl   <= 21'h00_0000;
      outcfg  <= 14'h0000;
      mask    <= 7'h00;
    end
    else
    begin
      if (wr && paddr == `MMPWM_OFF_CTRL)
        ctrl <= pwdata;
      else
        for (int i = 0; i < NMATCH; i++)
          if (hit[i] && mctrl[3*i])
            ctrl[`MMPWM_CTRL_RUN] <= 1'b0;
      if (wr && paddr == `MMPWM_OFF_PRESC)
        presc_r <= pwdata;
      if (wr && paddr == `MMPWM_OFF_MCTRL)
        mctrl <= pwdata[20:0];
      if (wr && paddr == `MMPWM_OFF_OUTCFG)
        outcfg <= pwdata[13:0];
      if (wr && paddr == `MMPWM_OFF_MASK)
        mask <= pwdata[6:0];
    end
  end

  // ==========================================================
  // timer counter: period match or reset-on-match clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tc <= 32'h0000_0000;
    else if (ctrl[`MMPWM_CTRL_RST])
      tc <= 32'h0000_0000;
    else if (wr && paddr == `MMPWM_OFF_COUNT)
      tc <= pwdata;
    else if (tif.tick)
    begin
      if ((ctrl[`MMPWM_CTRL_PWM] && period_hit) ||
          |(hit & match_bits(mctrl, 1)))
        tc <= 32'h0000_0000;
      else if (|(hit & match_bits(mctrl, 0)))
        tc <= tc;                                    // stop keeps the match count
      else
        tc <= tc + 32'h0000_0001;
    end
  end

  // ==========================================================
  // shadow writes, release latch and transfer at period match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rel <= 7'h00;
      for (int i = 0; i < NMATCH; i++)
      begin
        shadow[i] <= `MMPWM_MATCH_RESET;
        active[i] <= `MMPWM_MATCH_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NMATCH; i++)
      begin
        if (!ctrl[`MMPWM_CTRL_PWM] || (rel[i] && period_hit))
          active[i] <= shadow[i];
        if (ctrl[`MMPWM_CTRL_PWM] && rel[i] && period_hit)
          rel[i] <= 1'b0;
        if (wr && paddr == `MMPWM_OFF_RELEASE && pwdata[i])
          rel[i] <= 1'b1;
      end
      if (wr && match_idx(paddr) != 3'd7)
        shadow[match_idx(paddr)] <= pwdata;
    end
  end

  // ==========================================================
  // pwm outputs: single and double edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_out <= 6'h00;
    else
      for (int n = 1; n <= 6; n++)
      begin
        if (!ctrl[`MMPWM_CTRL_PWM] || !outcfg[n])
          pwm_out[n] <= 1'b0;
        else if (n >= 2 && outcfg[n+7])
        begin
          // double edge: rise on match n-1, fall on match n
          if (hit[n])
            pwm_out[n] <= 1'b0;
          else if (hit[n-1])
            pwm_out[n] <= 1'b1;
        end
        else
        begin
          // single edge: rise at period, fall as the count reaches match n,
          // so the width is match n ticks; rise wins for a full-period width
          if (period_hit && active[n] != 32'h0000_0000)
            pwm_out[n] <= 1'b1;
          else if (fall_hit[n])
            pwm_out[n] <= 1'b0;
        end
      end
  end

  // ==========================================================
  // sticky interrupt status, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= 7'h00;
    else
      for (int i = 0; i < NMATCH; i++)
        if (hit[i] && mctrl[3*i+2])
          status[i] <= 1'b1;
        else if (wr && paddr == `MMPWM_OFF_STATUS && pwdata[i])
          status[i] <= 1'b0;
  end
  assign irq = |(status & mask);

  // ==========================================================
  // read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (rd && !penable)
    begin
      pslverr <= 1'b0;
      case (paddr)
        `MMPWM_OFF_CTRL:    prdata <= ctrl;
        `MMPWM_OFF_COUNT:   prdata <= tc;
        `MMPWM_OFF_PRESC:   prdata <= presc_r;
        `MMPWM_OFF_PCOUNT:  prdata <= tif.pcount;
        `MMPWM_OFF_MCTRL:   prdata <= {11'h000, mctrl};
        `MMPWM_OFF_OUTCFG:  prdata <= {18'h0_0000, outcfg};
        `MMPWM_OFF_RELEASE: prdata <= {25'h000_0000, rel};
        `MMPWM_OFF_STATUS:  prdata <= {25'h000_0000, status};
        `MMPWM_OFF_MASK:    prdata <= {25'h000_0000, mask};
        default:
        begin
          if (match_idx(paddr) != 3'd7)
            prdata <= shadow[match_idx(paddr)];
          else
            prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  property p_period_clear;
    @(posedge pclk) disable iff (!presetn)
    (ctrl[`MMPWM_CTRL_PWM] && !ctrl[`MMPWM_CTRL_RST] && period_hit && !wr) |=> (tc == 32'h0);
  endproperty
  a_period_clear: assert property (p_period_clear) else $error("period match did not clear");
  property p_disabled_low;
    @(posedge pclk) disable iff (!presetn)
    (!outcfg[1]) |=> (pwm_out[1] == 1'b0);
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("disabled output high");
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (hit[0] && mctrl[2]) |=> status[0];
  endproperty
  a_irq: assert property (p_irq) else $error("match irq not latched");

  // ==========================================================
  // stop-on-match and counter hold checks
  property p_stop_on_match;
    @(posedge pclk) disable iff (!presetn)
    (ctrl[`MMPWM_CTRL_RUN] && |(hit & match_bits(mctrl, 0)) && !wr) |=> !ctrl[`MMPWM_CTRL_RUN];
  endproperty
  a_stop_on_match: assert property (p_stop_on_match) else $error("stop missed");

  property p_count_hold;
    @(posedge pclk) disable iff (!presetn)
    (!tif.tick && !ctrl[`MMPWM_CTRL_RST] && !wr) |=> $stable(tc);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved untimed");

  // ==========================================================
  // single-edge output checks, and all outputs low while pwm is off
  property p_single_rise;
    @(posedge pclk) disable iff (!presetn)
    (ctrl[`MMPWM_CTRL_PWM] && outcfg[1] && period_hit && active[1] != 32'h0) |=> pwm_out[1];
  endproperty
  a_single_rise: assert property (p_single_rise) else $error("no rise at period");

  property p_single_fall;
    @(posedge pclk) disable iff (!presetn)
    (ctrl[`MMPWM_CTRL_PWM] && outcfg[1] && fall_hit[1] && !period_hit) |=> !pwm_out[1];
  endproperty
  a_single_fall: assert property (p_single_fall) else $error("no fall at match");

  property p_pwm_off_low;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl[`MMPWM_CTRL_PWM]) |=> (pwm_out == 6'h00);
  endproperty
  a_pwm_off_low: assert property (p_pwm_off_low) else $error("output high, pwm off");

  // ==========================================================
  // double-edge output checks: rise on match 3, fall on match 4
  sequence s_dbl_rise;
    ctrl[`MMPWM_CTRL_PWM] && outcfg[4] && outcfg[11] && hit[3] && !hit[4];
  endsequence
  sequence s_dbl_fall;
    ctrl[`MMPWM_CTRL_PWM] && outcfg[4] && outcfg[11] && hit[4];
  endsequence
  property p_double_rise;
    @(posedge pclk) disable iff (!presetn)
    s_dbl_rise |=> pwm_out[4];
  endproperty
  a_double_rise: assert property (p_double_rise) else $error("double rise missed");

  property p_double_fall;
    @(posedge pclk) disable iff (!presetn)
    s_dbl_fall |=> !pwm_out[4];
  endproperty
  a_double_fall: assert property (p_double_fall) else $error("double fall missed");

  // ==========================================================
  // shadow transfer checks
  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    (ctrl[`MMPWM_CTRL_PWM] && rel[1] && period_hit) |=> (active[1] == $past(shadow[1]));
  endproperty
  a_reload: assert property (p_reload) else $error("release not loaded");

  property p_hold_unreleased;
    @(posedge pclk) disable iff (!presetn)
    (ctrl[`MMPWM_CTRL_PWM] && !rel[1]) |=> $stable(active[1]);
  endproperty
  a_hold_unreleased: assert property (p_hold_unreleased) else $error("early load");
endmodule : mmpwm_unit

// [mmpwm_load.sv]
// ==========================================================
// external load: measures high time and rise-to-rise period of each output
module mmpwm_load (
  input  wire logic       pclk,
  input  wire logic [6:1] pwm_out,
  output logic      [15:0] hi_len [6:1],
  output logic      [15:0] per_len [6:1]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] hc [6:1];
  logic [15:0] pc [6:1];
  logic [6:1]  last;
  // clear the meters so an output that never pulses reads zero
  initial
  begin
    last = '0;
    for (int i = 1; i <= 6; i++)
    begin
      hc[i] = '0;
      pc[i] = '0;
      hi_len[i] = '0;
      per_len[i] = '0;
    end
  end
  // count high cycles per pulse and cycles between rising edges
  always @(posedge pclk)
  begin
    last <= pwm_out;
    for (int i = 1; i <= 6; i++)
    begin
      if (pwm_out[i])
        hc[i] <= hc[i] + 16'h0001;
      else if (last[i])
      begin
        hi_len[i] <= hc[i];
        hc[i] <= '0;
      end
      if (pwm_out[i] && !last[i])
      begin
        per_len[i] <= pc[i];
        pc[i] <= 16'h0001;
      end
      else
        pc[i] <= pc[i] + 16'h0001;
    end
  end
endmodule : mmpwm_load

// [mmpwm_unit_tb_top.sv]
`include "mmpwm_map.svh"
module mmpwm_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  cap_in;
  logic [6:1]  pwm_out;
  logic [15:0] hi_len [6:1];
  logic [15:0] per_len [6:1];
  logic [31:0] exp_q [$];
  logic [31:0] mv [0:6];
  logic [31:0] exp_hi [1:6];
  int          errors, samples_checked, seed, n, m;
  // ==========================================================
  // design and load
  mmpwm_unit #(.NMATCH(7)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq));
  mmpwm_load u_load (.pclk(pclk), .pwm_out(pwm_out), .hi_len(hi_len), .per_len(per_len));
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // note the expectation, the monitor compares it
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // read data monitor
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
      chk(prdata, exp_q.pop_front());
  // watchdog
  initial
  begin
    #200000;
    errors++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    seed = 66;
    errors = 0;
    samples_checked = 0;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cap_in = 2'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`MMPWM_OFF_CTRL, `MMPWM_CTRL_RESET);
    rd(`MMPWM_OFF_MATCH0, `MMPWM_MATCH_RESET);
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0000_0000);
    $display("test reset done");
    // timer mode, stop on match 3
    wr(`MMPWM_OFF_MATCH0 + 12'h00c, 32'h0000_0014);
    wr(`MMPWM_OFF_MCTRL, 32'h0000_0200);
    wr(`MMPWM_OFF_CTRL, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    rd(`MMPWM_OFF_COUNT, 32'h0000_0014);
    $display("test timer done");
    // counter mode on rising edges of capture input 0, input 1 noise
    wr(`MMPWM_OFF_MCTRL, 32'h0000_0000);
    wr(`MMPWM_OFF_CTRL, 32'h0000_0002);
    wr(`MMPWM_OFF_CTRL, 32'h0000_0029);
    n = 1 + ($random(seed) & 7);
    for (int i = 0; i < n; i++)
    begin
      cap_in <= {1'($random(seed)), 1'b1};
      repeat (3) @(posedge pclk);
      cap_in <= {1'($random(seed)), 1'b0};
      repeat (3) @(posedge pclk);
    end
    repeat (5) @(posedge pclk);
    rd(`MMPWM_OFF_COUNT, 32'(n));
    $display("test counter done");
    // pwm: period 10, out1 random width, out2 constant low, out3 width 2,
    // out4 positive double pulse, out5 disabled, out6 negative double pulse
    m = 1 + ($random(seed) & 7);
    mv = '{32'h9, 32'(m), 32'h0, 32'h2, 32'h6, 32'h6, 32'h2};
    exp_hi = '{32'(m), 32'h0, 32'h2, 32'h4, 32'h0, 32'h6};
    wr(`MMPWM_OFF_CTRL, 32'h0000_0002);
    wr(`MMPWM_OFF_MCTRL, 32'h0000_0006);
    for (int k = 0; k < 7; k++)
      wr(`MMPWM_OFF_MATCH0 + 12'(4 * k), mv[k]);
    wr(`MMPWM_OFF_OUTCFG, 32'h0000_285e);
    wr(`MMPWM_OFF_RELEASE, 32'h0000_007f);
    wr(`MMPWM_OFF_MASK, 32'h0000_0000);
    wr(`MMPWM_OFF_CTRL, 32'h0000_0005);
    repeat (40) @(posedge pclk);
    for (int i = 1; i <= 6; i++)
      chk({16'h0000, hi_len[i]}, exp_hi[i]);
    chk({16'h0000, per_len[1]}, 32'h0000_000a);
    chk({16'h0000, per_len[6]}, 32'h0000_000a);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`MMPWM_OFF_MASK, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    $display("test pwm done");
    // a new width stays inactive until released, then applies at period
    wr(`MMPWM_OFF_MATCH0 + 12'h004, 32'(9 - m));
    repeat (30) @(posedge pclk);
    chk({16'h0000, hi_len[1]}, 32'(m));
    wr(`MMPWM_OFF_RELEASE, 32'h0000_0002);
    repeat (30) @(posedge pclk);
    chk({16'h0000, hi_len[1]}, 32'(9 - m));
    $display("test release done");
    // stop, then clear the sticky status
    wr(`MMPWM_OFF_CTRL, 32'h0000_0004);
    rd(`MMPWM_OFF_STATUS, 32'h0000_0001);
    wr(`MMPWM_OFF_STATUS, 32'h0000_0001);
    rd(`MMPWM_OFF_STATUS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test interrupt done");
    conclude();
  end
endmodule : mmpwm_unit_tb_top
